// ==== common/sldcc_pkg.sv ====
// Constants shared by the lane digital configuration block and its chain engine
`default_nettype none
package sldcc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_LANE_DIGITAL_CONFIG = 8'h00;
  localparam logic [7:0] OFS_LANE_MISC_CONFIG    = 8'h18;
  localparam logic [7:0] OFS_CHAIN_SELECT        = 8'h20;
  localparam logic [7:0] OFS_CHAIN_RD_INDEX      = 8'h24;
  localparam logic [7:0] OFS_CHAIN_RD_DATA       = 8'h28;

  // lane_digital_config fields
  localparam int unsigned DIG_AST_LSB   = 3;
  localparam int unsigned DIG_DEAST_LSB = 0;
  localparam int unsigned DELAY_CODE_W  = 3;
  localparam logic [31:0] DIG_WR_MASK   = 32'h0000_003f;
  localparam logic [31:0] DIG_RESET     = 32'h0000_0000;

  // lane_misc_config fields
  localparam int unsigned MISC_FX_BIT    = 8;
  localparam int unsigned MISC_RXLP_BIT  = 5;
  localparam int unsigned MISC_TXLP_BIT  = 4;
  localparam int unsigned MISC_RXINV_BIT = 3;
  localparam int unsigned MISC_TXINV_BIT = 2;
  localparam int unsigned MISC_RST_BIT   = 0;
  localparam logic [31:0] MISC_WR_MASK   = 32'h0000_013d;
  localparam logic [31:0] MISC_RESET     = 32'h0000_0000;

  // chain_slave_select_trigger fields
  localparam int unsigned SEL_WR_BIT  = 31;
  localparam int unsigned SEL_RD_BIT  = 30;
  localparam int unsigned N_SLAVES    = 16;
  localparam logic [15:0] SEL_RESET   = 16'hffff;
  localparam int unsigned IDX_W       = 4;

  // Chain frame: one word per slave, bit 15 marks the slave as addressed
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CFG_W       = 15;
  localparam int unsigned WORD_EN_BIT = 15;
  localparam int unsigned FRAME_W     = N_SLAVES * WORD_W;
  localparam logic [7:0]  LAST_SHIFT  = 8'hff;

  // Lane data path
  localparam int unsigned DATA_W = 20;

  // Signal-detect filter times in microseconds, and the clock rate
  localparam int unsigned CLK_MHZ    = 50;
  localparam int unsigned AST_US_1   = 35;
  localparam int unsigned AST_US_2   = 70;
  localparam int unsigned AST_US_3   = 105;
  localparam int unsigned AST_US_4   = 140;
  localparam int unsigned DEAST_US_1 = 250;
  localparam int unsigned DEAST_US_2 = 350;
  localparam int unsigned DEAST_US_3 = 450;
  localparam int unsigned DEAST_US_4 = 550;
  localparam int unsigned CNT_W      = 15;

  localparam int unsigned AST_CYC_1   = AST_US_1 * CLK_MHZ;
  localparam int unsigned AST_CYC_2   = AST_US_2 * CLK_MHZ;
  localparam int unsigned AST_CYC_3   = AST_US_3 * CLK_MHZ;
  localparam int unsigned AST_CYC_4   = AST_US_4 * CLK_MHZ;
  localparam int unsigned DEAST_CYC_1 = DEAST_US_1 * CLK_MHZ;
  localparam int unsigned DEAST_CYC_2 = DEAST_US_2 * CLK_MHZ;
  localparam int unsigned DEAST_CYC_3 = DEAST_US_3 * CLK_MHZ;
  localparam int unsigned DEAST_CYC_4 = DEAST_US_4 * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DONE  = 4'b1000
  } sldcc_state_type;

endpackage : sldcc_pkg
`default_nettype wire

// ==== src/sldcc_sigdet_filter.sv ====
// Signal-detect filter: a level change must persist for the selected time
`timescale 1ns/1ns
`default_nettype none
module sldcc_sigdet_filter (
  input  wire logic                      hclk,          // Clock
  input  wire logic                      hresetn,       // Async reset, active low
  input  wire logic                      sig_raw,       // Unfiltered detect level
  input  wire logic [sldcc_pkg::CNT_W-1:0] assert_cyc,  // Cycles high before assert
  input  wire logic [sldcc_pkg::CNT_W-1:0] deassert_cyc,// Cycles low before drop
  output logic                           sig_det        // Filtered detect level
);

  logic                        sig_det_r;
  logic [sldcc_pkg::CNT_W-1:0] cnt_r;
  logic [sldcc_pkg::CNT_W-1:0] limit;

  assign sig_det = sig_det_r;
  assign limit   = sig_det_r ? deassert_cyc : assert_cyc;

  // Any glitch back to the current level restarts the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= '0;
      sig_det_r <= 1'b0;
    end else if (sig_raw == sig_det_r) begin
      cnt_r <= '0;
    end else if (cnt_r >= limit) begin
      cnt_r     <= '0;
      sig_det_r <= sig_raw;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : sldcc_sigdet_filter
`default_nettype wire

// ==== src/sldcc_top.sv ====
// Lane digital configuration registers, lane data path and configuration chain master
//
// Behaviour
// - Assert delay code at bits 5:3 picks 0/35/70/105/140 us; 5..7 reserved.
// - De-assert delay code picks 0/250/350/450/550 us; 5..7 reserved.
// - Misc bit 8 turns on deserializer special handling for 100FX.
// - Misc bit 5 lets the PCS idle machine power down the receiver.
// - Misc bit 4 lets the PCS idle machine power down the transmitter.
// - Misc bit 3 inverts every received data bit.
// - Misc bit 2 inverts every transmitted data bit.
// - Misc bit 0 holds lane reset until software writes zero.
// - Every macro has a slave on one serial daisy-chain loop.
// - Bit 31 starts chain write, stays one until write finished.
// - Bit 30 starts chain read, stays one until read finished.
// - Sixteen-bit select, one bit per macro, reset all ones, includes macro n when set.
`timescale 1ns/1ns
`default_nettype none
module sldcc_top #(
  parameter int unsigned AST_CYC_1   = sldcc_pkg::AST_CYC_1,
  parameter int unsigned AST_CYC_2   = sldcc_pkg::AST_CYC_2,
  parameter int unsigned AST_CYC_3   = sldcc_pkg::AST_CYC_3,
  parameter int unsigned AST_CYC_4   = sldcc_pkg::AST_CYC_4,
  parameter int unsigned DEAST_CYC_1 = sldcc_pkg::DEAST_CYC_1,
  parameter int unsigned DEAST_CYC_2 = sldcc_pkg::DEAST_CYC_2,
  parameter int unsigned DEAST_CYC_3 = sldcc_pkg::DEAST_CYC_3,
  parameter int unsigned DEAST_CYC_4 = sldcc_pkg::DEAST_CYC_4
) (
  input  wire logic                         hclk,                  // Bus clock
  input  wire logic                         hresetn,               // Async reset, active low
  input  wire logic                         hsel,                  // Slave select
  input  wire logic [31:0]                  haddr,                 // Byte address
  input  wire logic [1:0]                   htrans,                // Transfer type
  input  wire logic                         hwrite,                // Write when high
  input  wire logic [2:0]                   hsize,                 // Transfer size
  input  wire logic [31:0]                  hwdata,                // Write data
  input  wire logic                         hready,                // Bus ready
  output logic                              hreadyout,             // Slave ready
  output logic                              hresp,                 // Response, always OKAY
  output logic [31:0]                       hrdata,                // Read data
  input  wire logic                         sigdet_raw,            // Analog level detect
  output logic                              sigdet_filtered,       // Filtered signal detect
  output logic                              fx_deser_special_handling_en, // 100FX handling
  input  wire logic                         pcs_rx_lpi_pwrdn,      // PCS asks rx power down
  input  wire logic                         pcs_tx_lpi_pwrdn,      // PCS asks tx power down
  output logic                              rx_power_down,         // Receiver powered down
  output logic                              tx_power_down,         // Transmitter powered down
  input  wire logic [sldcc_pkg::DATA_W-1:0] deser_data,            // Data from deserializer
  output logic [sldcc_pkg::DATA_W-1:0]      rx_data,               // Data toward PCS
  input  wire logic [sldcc_pkg::DATA_W-1:0] pcs_tx_data,           // Data from PCS
  output logic [sldcc_pkg::DATA_W-1:0]      ser_data,              // Data toward serializer
  output logic                              lane_reset,            // Lane reset, active high
  output logic                              chain_sdo,             // Chain serial out
  input  wire logic                         chain_sdi,             // Chain serial return
  output logic                              chain_shift_en,        // Chain shifts this cycle
  output logic                              chain_capture,         // Slaves load their state
  output logic                              chain_update           // Addressed slaves apply
);

  localparam int unsigned FW = sldcc_pkg::FRAME_W;

  // Bus slave state
  logic                     hreadyout_r;
  logic                     hresp_r;
  logic [31:0]              hrdata_r;
  logic                     wr_pend_r;
  logic [7:0]               wr_addr_r;
  logic                     addr_phase;

  // Registers
  logic [31:0]              dig_cfg_r;
  logic [31:0]              misc_cfg_r;
  logic [15:0]              chain_sel_r;
  logic                     wr_trig_r;
  logic                     rd_trig_r;
  logic [sldcc_pkg::IDX_W-1:0] rd_idx_r;
  logic [sldcc_pkg::CFG_W-1:0] rb_mem [sldcc_pkg::N_SLAVES];

  // Lane path
  logic                     fx_en_r;
  logic                     rx_pd_r;
  logic                     tx_pd_r;
  logic [sldcc_pkg::DATA_W-1:0] rx_data_r;
  logic [sldcc_pkg::DATA_W-1:0] ser_data_r;
  logic                     lane_rst_r;
  logic [sldcc_pkg::CNT_W-1:0] ast_cyc;
  logic [sldcc_pkg::CNT_W-1:0] deast_cyc;

  // Chain engine
  sldcc_pkg::sldcc_state_type state_r;
  logic [FW-1:0]            sr_r;
  logic [7:0]               shift_cnt_r;
  logic                     op_is_rd_r;
  logic                     sdo_r;
  logic                     shift_en_r;
  logic                     capture_r;
  logic                     update_r;
  logic                     start_wr;
  logic                     start_rd;
  logic [FW-1:0]            wr_frame;

  // Bit position of slave n's word in the frame; slave 15 sits next to the output
  function automatic int unsigned slot_lsb(input int unsigned n);
    slot_lsb = (sldcc_pkg::N_SLAVES - 1 - n) * sldcc_pkg::WORD_W;
  endfunction : slot_lsb

  // Delay code to cycle count; reserved codes behave as no delay
  function automatic logic [sldcc_pkg::CNT_W-1:0] delay_cyc(
    input logic [sldcc_pkg::DELAY_CODE_W-1:0] code,
    input int unsigned c1, input int unsigned c2,
    input int unsigned c3, input int unsigned c4);
    unique case (code)
      3'h1:    delay_cyc = sldcc_pkg::CNT_W'(c1);
      3'h2:    delay_cyc = sldcc_pkg::CNT_W'(c2);
      3'h3:    delay_cyc = sldcc_pkg::CNT_W'(c3);
      3'h4:    delay_cyc = sldcc_pkg::CNT_W'(c4);
      default: delay_cyc = '0;
    endcase
  endfunction : delay_cyc

  // Unmapped offsets read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    read_mux = 32'h0000_0000;
    unique case (a)
      sldcc_pkg::OFS_LANE_DIGITAL_CONFIG: read_mux = dig_cfg_r;
      sldcc_pkg::OFS_LANE_MISC_CONFIG:    read_mux = misc_cfg_r;
      sldcc_pkg::OFS_CHAIN_SELECT: begin
        read_mux[sldcc_pkg::SEL_WR_BIT] = wr_trig_r;
        read_mux[sldcc_pkg::SEL_RD_BIT] = rd_trig_r;
        read_mux[15:0]                  = chain_sel_r;
      end
      sldcc_pkg::OFS_CHAIN_RD_INDEX:      read_mux[sldcc_pkg::IDX_W-1:0] = rd_idx_r;
      sldcc_pkg::OFS_CHAIN_RD_DATA:       read_mux[sldcc_pkg::CFG_W-1:0] = rb_mem[rd_idx_r];
      default:                            read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  assign hreadyout                    = hreadyout_r;
  assign hresp                        = hresp_r;
  assign hrdata                       = hrdata_r;
  assign fx_deser_special_handling_en = fx_en_r;
  assign rx_power_down                = rx_pd_r;
  assign tx_power_down                = tx_pd_r;
  assign rx_data                      = rx_data_r;
  assign ser_data                     = ser_data_r;
  assign lane_reset                   = lane_rst_r;
  assign chain_sdo                    = sdo_r;
  assign chain_shift_en               = shift_en_r;
  assign chain_capture                = capture_r;
  assign chain_update                 = update_r;

  assign addr_phase = hsel & hready & htrans[1];

  // Zero wait states: every transfer completes in its first data-phase cycle
  // Ready is held low during reset so no transfer is taken early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b0;
      hresp_r     <= 1'b0;
      hrdata_r    <= 32'h0000_0000;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      wr_pend_r   <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_r <= {haddr[7:2], 2'b00};
      end
      if (addr_phase && !hwrite) begin
        hrdata_r <= read_mux({haddr[7:2], 2'b00});
      end
    end
  end

  // Lane configuration words
  // Write masks keep reserved and unused bits reading zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_cfg_r  <= sldcc_pkg::DIG_RESET;
      misc_cfg_r <= sldcc_pkg::MISC_RESET;
      rd_idx_r   <= '0;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        sldcc_pkg::OFS_LANE_DIGITAL_CONFIG: dig_cfg_r  <= hwdata & sldcc_pkg::DIG_WR_MASK;
        sldcc_pkg::OFS_LANE_MISC_CONFIG:    misc_cfg_r <= hwdata & sldcc_pkg::MISC_WR_MASK;
        sldcc_pkg::OFS_CHAIN_RD_INDEX:      rd_idx_r   <= hwdata[sldcc_pkg::IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // Triggers start only from idle; the select vector is written regardless
  assign start_wr = wr_pend_r && (wr_addr_r == sldcc_pkg::OFS_CHAIN_SELECT)
                    && hwdata[sldcc_pkg::SEL_WR_BIT] && state_r == sldcc_pkg::ST_IDLE;
  // A simultaneous write request takes precedence over the read request
  assign start_rd = wr_pend_r && (wr_addr_r == sldcc_pkg::OFS_CHAIN_SELECT)
                    && hwdata[sldcc_pkg::SEL_RD_BIT] && !hwdata[sldcc_pkg::SEL_WR_BIT]
                    && state_r == sldcc_pkg::ST_IDLE;

  // Select vector and trigger bits; a trigger written while busy is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_sel_r <= sldcc_pkg::SEL_RESET;
      wr_trig_r   <= 1'b0;
      rd_trig_r   <= 1'b0;
    end else begin
      if (wr_pend_r && wr_addr_r == sldcc_pkg::OFS_CHAIN_SELECT) begin
        chain_sel_r <= hwdata[15:0];
      end
      // Trigger bits are cleared only by the engine reaching done
      if (start_wr) begin
        wr_trig_r <= 1'b1;
      end else if (state_r == sldcc_pkg::ST_DONE && !op_is_rd_r) begin
        wr_trig_r <= 1'b0;
      end
      if (start_rd) begin
        rd_trig_r <= 1'b1;
      end else if (state_r == sldcc_pkg::ST_DONE && op_is_rd_r) begin
        rd_trig_r <= 1'b0;
      end
    end
  end

  // Outgoing frame: each slave gets the lane settings plus its own enable mark
  always_comb begin
    wr_frame = '0;
    for (int unsigned n = 0; n < sldcc_pkg::N_SLAVES; n++) begin
      wr_frame[slot_lsb(n) +: sldcc_pkg::WORD_W] =
        {chain_sel_r[n], misc_cfg_r[8:0], dig_cfg_r[5:0]};
    end
  end

  // Chain engine: load, shift the whole loop once, then apply or store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= sldcc_pkg::ST_IDLE;
      sr_r        <= '0;
      shift_cnt_r <= 8'h00;
      op_is_rd_r  <= 1'b0;
      sdo_r       <= 1'b0;
      shift_en_r  <= 1'b0;
      capture_r   <= 1'b0;
      update_r    <= 1'b0;
    end else begin
      capture_r <= 1'b0;
      update_r  <= 1'b0;
      unique case (state_r)
        sldcc_pkg::ST_IDLE: begin
          if (start_wr || start_rd) begin
            sr_r       <= start_wr ? wr_frame : '0;
            op_is_rd_r <= start_rd;
            capture_r  <= start_rd;
            state_r    <= sldcc_pkg::ST_LOAD;
          end
        end

        sldcc_pkg::ST_LOAD: begin
          sdo_r       <= sr_r[0];
          shift_en_r  <= 1'b1;
          shift_cnt_r <= 8'h00;
          state_r     <= sldcc_pkg::ST_SHIFT;
        end

        sldcc_pkg::ST_SHIFT: begin
          // The loop is one frame long, so after the last shift sr holds what came back
          sr_r        <= {chain_sdi, sr_r[FW-1:1]};
          sdo_r       <= sr_r[1];
          shift_cnt_r <= shift_cnt_r + 8'h01;
          if (shift_cnt_r == sldcc_pkg::LAST_SHIFT) begin
            shift_en_r <= 1'b0;
            sdo_r      <= 1'b0;
            state_r    <= sldcc_pkg::ST_DONE;
          end
        end

        sldcc_pkg::ST_DONE: begin
          // Only a write asks the slaves to apply; a read leaves them untouched
          update_r <= !op_is_rd_r;
          state_r  <= sldcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Readable copies of the slaves' state; only selected slaves are refreshed
  // Copies have no reset: they read unknown until the first chain read fills them
  always_ff @(posedge hclk) begin
    if (state_r == sldcc_pkg::ST_DONE && op_is_rd_r) begin
      for (int unsigned n = 0; n < sldcc_pkg::N_SLAVES; n++) begin
        if (chain_sel_r[n]) begin
          rb_mem[n] <= sr_r[slot_lsb(n) +: sldcc_pkg::CFG_W];
        end
      end
    end
  end

  // Filter counts are parameters so a bench can shorten the long filter times
  assign ast_cyc   = delay_cyc(dig_cfg_r[sldcc_pkg::DIG_AST_LSB +: sldcc_pkg::DELAY_CODE_W],
                               AST_CYC_1, AST_CYC_2, AST_CYC_3, AST_CYC_4);
  assign deast_cyc = delay_cyc(dig_cfg_r[sldcc_pkg::DIG_DEAST_LSB +: sldcc_pkg::DELAY_CODE_W],
                               DEAST_CYC_1, DEAST_CYC_2, DEAST_CYC_3, DEAST_CYC_4);

  // A glitch back to the present level restarts the filter count
  sldcc_sigdet_filter u_sigdet (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sig_raw      (sigdet_raw),
    .assert_cyc   (ast_cyc),
    .deassert_cyc (deast_cyc),
    .sig_det      (sigdet_filtered)
  );

  // Lane controls and data path, one register stage each way
  // Power-down follows the PCS request only while its enable bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fx_en_r    <= 1'b0;
      rx_pd_r    <= 1'b0;
      tx_pd_r    <= 1'b0;
      lane_rst_r <= 1'b0;
    end else begin
      fx_en_r    <= misc_cfg_r[sldcc_pkg::MISC_FX_BIT];
      rx_pd_r    <= misc_cfg_r[sldcc_pkg::MISC_RXLP_BIT] & pcs_rx_lpi_pwrdn;
      tx_pd_r    <= misc_cfg_r[sldcc_pkg::MISC_TXLP_BIT] & pcs_tx_lpi_pwrdn;
      lane_rst_r <= misc_cfg_r[sldcc_pkg::MISC_RST_BIT];
    end
  end

  // Inversion is a whole-word XOR, so both directions keep one cycle of latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_r  <= '0;
      ser_data_r <= '0;
    end else begin
      rx_data_r  <= deser_data ^ {sldcc_pkg::DATA_W{misc_cfg_r[sldcc_pkg::MISC_RXINV_BIT]}};
      ser_data_r <= pcs_tx_data ^ {sldcc_pkg::DATA_W{misc_cfg_r[sldcc_pkg::MISC_TXINV_BIT]}};
    end
  end

endmodule : sldcc_top
`default_nettype wire

// ==== tb/sldcc_monitor.sv ====
// Port checker for the lane configuration block
`timescale 1ns/1ns
`default_nettype none
module sldcc_monitor (
  input wire logic                         hclk,             // Clock
  input wire logic                         hresetn,          // Reset
  input wire logic                         hresp,            // Response
  input wire logic [sldcc_pkg::DATA_W-1:0] deser_data,       // Rx in
  input wire logic [sldcc_pkg::DATA_W-1:0] rx_data,          // Rx out
  input wire logic [sldcc_pkg::DATA_W-1:0] pcs_tx_data,      // Tx in
  input wire logic [sldcc_pkg::DATA_W-1:0] ser_data,         // Tx out
  input wire logic                         pcs_rx_lpi_pwrdn, // Rx request
  input wire logic                         pcs_tx_lpi_pwrdn, // Tx request
  input wire logic                         rx_power_down,    // Rx off
  input wire logic                         tx_power_down,    // Tx off
  input wire logic                         chain_shift_en,   // Shift
  input wire logic                         chain_capture,    // Capture
  input wire logic                         chain_update      // Update
);
  logic [8:0] run_r;

  // Length of the current shift burst
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 9'h000;
    end else begin
      run_r <= chain_shift_en ? run_r + 9'h001 : 9'h000;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_shift_start;
    !chain_shift_en ##1 chain_shift_en;
  endsequence
  sequence s_pulse_end;
    chain_update ##1 !chain_update;
  endsequence

  AST_SHIFT_LEN: assert property ($fell(chain_shift_en) |-> run_r == 9'h100)
    else $error("shift burst length wrong");
  AST_CAPTURE_START: assert property (chain_capture |-> s_shift_start)
    else $error("capture not followed by shifting");
  AST_UPDATE_PULSE: assert property ($rose(chain_update) |-> $past(chain_shift_en, 2) ##0 s_pulse_end)
    else $error("update pulse misplaced");
  AST_RX_INV: assert property ($countones(rx_data ^ $past(deser_data)) inside {0, sldcc_pkg::DATA_W})
    else $error("rx data not whole-word inverted or passed");
  AST_TX_INV: assert property ($countones(ser_data ^ $past(pcs_tx_data)) inside {0, sldcc_pkg::DATA_W})
    else $error("tx data not whole-word inverted or passed");
  AST_RX_PD: assert property (rx_power_down |-> $past(pcs_rx_lpi_pwrdn))
    else $error("rx power down without request");
  AST_TX_PD: assert property (tx_power_down |-> $past(pcs_tx_lpi_pwrdn))
    else $error("tx power down without request");
  AST_HRESP: assert property (hresp == 1'b0)
    else $error("bus response not okay");
endmodule : sldcc_monitor

bind sldcc_top sldcc_monitor mon_u (.hclk, .hresetn, .hresp, .deser_data, .rx_data, .pcs_tx_data, .ser_data,
  .pcs_rx_lpi_pwrdn, .pcs_tx_lpi_pwrdn, .rx_power_down, .tx_power_down, .chain_shift_en, .chain_capture,
  .chain_update);
`default_nettype wire

// ==== tb/sldcc_chain_model.sv ====
// Chain of macro slaves modelled as one 256-bit loop
`timescale 1ns/1ns
`default_nettype none
module sldcc_chain_model (
  input  wire logic hclk,           // Clock
  input  wire logic chain_sdo,      // Serial in
  input  wire logic chain_shift_en, // Shift strobe
  output logic      chain_sdi       // Serial return
);
  logic [255:0] loop_r;

  // Each slave holds its word in the loop, so a frame returns what was last sent
  always_ff @(posedge hclk) begin
    if (chain_shift_en) begin
      loop_r <= {loop_r[254:0], chain_sdo};
    end
  end

  // Outside a frame the return line carries the inverse of the last loop bit
  assign chain_sdi = chain_shift_en ? loop_r[255] : ~loop_r[255];
endmodule : sldcc_chain_model
`default_nettype wire

// ==== tb/sldcc_tb.sv ====
// Self-checking bench for the lane configuration block
`timescale 1ns/1ns
`default_nettype none
module sldcc_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sigdet_raw = 1'b0;
  logic        pcs_rx_lpi_pwrdn = 1'b0, pcs_tx_lpi_pwrdn = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [19:0] deser_data = 20'h0, pcs_tx_data = 20'h0, rx_data, ser_data;
  logic        hreadyout, hresp, sigdet_filtered, fx_deser_special_handling_en, rx_power_down, tx_power_down;
  logic        lane_reset, chain_sdo, chain_sdi, chain_shift_en, chain_capture, chain_update;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  // Short de-assert counts keep the run brief; assert counts run at full length
  sldcc_top #(.DEAST_CYC_1(4), .DEAST_CYC_2(6), .DEAST_CYC_3(8), .DEAST_CYC_4(10)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .sigdet_raw, .sigdet_filtered, .fx_deser_special_handling_en, .pcs_rx_lpi_pwrdn,
    .pcs_tx_lpi_pwrdn, .rx_power_down, .tx_power_down, .deser_data, .rx_data, .pcs_tx_data, .ser_data,
    .lane_reset, .chain_sdo, .chain_sdi, .chain_shift_en, .chain_capture, .chain_update);

  sldcc_chain_model far_u (.hclk, .chain_sdo, .chain_shift_en, .chain_sdi);

  always #10 hclk = ~hclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rdc

  // Polls the trigger bits; the count bounds how long a transfer ran
  task automatic wait_idle(output int n);
    logic [31:0] x;
    n = 0;
    do begin
      ahb(1'b0, 8'h20, 32'h0, x);
      n++;
    end while (x[31:30] !== 2'b00 && n < 400);
  endtask : wait_idle

  task automatic t_reset();
    rdc(8'h00, 32'h0, "dig reset");
    rdc(8'h18, 32'h0, "misc reset");
    rdc(8'h20, 32'h0000_ffff, "select reset");
    rdc(8'h2c, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_misc();
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[0] ? 32'h0 : 32'h0000_013d;
      wr(8'h18, i[0] ? 32'h0 : 32'hffff_ffff);
      deser_data <= 20'h3c5a1 ^ {20{i[0]}};
      pcs_tx_data <= 20'h0f96e ^ {20{i[0]}};
      pcs_rx_lpi_pwrdn <= ~i[1];
      pcs_tx_lpi_pwrdn <= i[1];
      rdc(8'h18, m, "misc");
      @(negedge hclk);
      chk("rx_data", {12'h0, deser_data ^ {20{m[3]}}}, {12'h0, rx_data});
      chk("ser_data", {12'h0, pcs_tx_data ^ {20{m[2]}}}, {12'h0, ser_data});
      chk("lane ctl", {28'h0, m[8], m[5] & ~i[1], m[4] & i[1], m[0]},
        {28'h0, fx_deser_special_handling_en, rx_power_down, tx_power_down, lane_reset});
      @(posedge hclk);
    end
    $display("test misc done");
  endtask : t_misc

  task automatic t_sigdet();
    int lim [2][8] = '{'{0, sldcc_pkg::AST_CYC_1, sldcc_pkg::AST_CYC_2, sldcc_pkg::AST_CYC_3,
      sldcc_pkg::AST_CYC_4, 0, 0, 0}, '{0, 4, 6, 8, 10, 0, 0, 0}};
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, {26'h0, c[2:0], c[2:0]});
      for (int d = 0; d < 2; d++) begin
        sigdet_raw <= ~d[0];
        n = 0;
        do begin
          @(posedge hclk);
          @(negedge hclk);
          n++;
        end while (sigdet_filtered !== ~d[0] && n < 8000);
        chk("detect time", 32'h1, {31'h0, n > lim[d][c] && n <= lim[d][c] + 3});
        @(posedge hclk);
      end
    end
    $display("test sigdet done");
  endtask : t_sigdet

  task automatic t_chain();
    int n;
    wr(8'h20, 32'h0000_0005);
    wr(8'h00, 32'h0000_002a);
    wr(8'h18, 32'h0000_000c);
    wr(8'h20, 32'h8000_0005);
    rdc(8'h20, 32'h8000_0005, "write pending");
    wait_idle(n);
    chk("write span", 32'h1, {31'h0, n > 120 && n < 400});
    // Changed after the write, so the copies must show the earlier frame
    wr(8'h00, 32'h0000_0011);
    wr(8'h20, 32'h4000_0005);
    rdc(8'h20, 32'h4000_0005, "read pending");
    wait_idle(n);
    chk("read span", 32'h1, {31'h0, n > 120 && n < 400});
    for (int s = 0; s < 3; s += 2) begin
      wr(8'h24, 32'(s));
      rdc(8'h28, 32'h0000_032a, "slave copy");
    end
    $display("test chain done");
  endtask : t_chain

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_misc();
    t_sigdet();
    t_chain();
    final_report();
  end
endmodule : sldcc_tb
`default_nettype wire
